// ==== logic/bank_timing_pkg.sv ====
// Constants, types and carriers for the bank address and skip timing block
package bank_timing_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;

    // Control register fields
    localparam int BE_POS = 0;
    localparam int BS_LSB = 4;
    localparam int PCC_LSB = 8;

    // Status register fields
    localparam int ST_BANK_LSB = 0;
    localparam int ST_SKIP_LSB = 4;
    localparam int ST_STALL_POS = 8;
    localparam int ST_TARGET_LSB = 16;

    // Operand widths
    typedef logic [3:0] nib_t;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] bitpos_t;
    typedef logic [3:0] bank_t;
    typedef logic [12:0] pc_t;
    typedef logic [11:0] dm_addr_t;

    // Values after reset
    localparam bank_t BS_RST = 4'h0;
    localparam logic [1:0] PCC_RST = 2'h0;

    // Banks
    localparam bank_t BANK_ZERO = 4'h0;
    localparam bank_t BANK_ONE = 4'h1;
    localparam bank_t BANK_TOP = 4'hF;

    // Data memory windows
    localparam byte_t DIRECT_LOW_TOP = 8'h7F;
    localparam byte_t FMEM_A_LO = 8'hB0;
    localparam byte_t FMEM_A_HI = 8'hBF;
    localparam byte_t FMEM_B_LO = 8'hF0;
    localparam byte_t FMEM_B_HI = 8'hFF;
    localparam byte_t PMEM_LO = 8'hC0;
    localparam byte_t PMEM_HI = 8'hFF;

    // Program memory windows
    localparam pc_t REL_BACK_MIN = 13'h0001;
    localparam pc_t REL_BACK_MAX = 13'h000F;
    localparam pc_t REL_FWD_MIN = 13'h0002;
    localparam pc_t REL_FWD_MAX = 13'h0010;
    localparam pc_t ROM_TOP = 13'h1F7F;
    localparam byte_t TADDR_LO = 8'h20;
    localparam byte_t TADDR_HI = 8'h7F;

    // Extra machine cycles of a taken skip
    localparam logic [1:0] SKIP_NONE = 2'h0;
    localparam logic [1:0] SKIP_ONE = 2'h1;
    localparam logic [1:0] SKIP_LONG = 2'h2;

    // Machine cycle lengths in pclk cycles, one per clock control setting
    localparam logic [5:0] MC_LEN_0 = 6'h02;
    localparam logic [5:0] MC_LEN_1 = 6'h04;
    localparam logic [5:0] MC_LEN_2 = 6'h20;

    typedef enum logic [2:0] {DM_HL, DM_DE, DM_DL, DM_MEM, DM_FMEM, DM_PMEM} dm_mode_e;
    typedef enum logic [2:0] {PM_REL, PM_CADDR, PM_FADDR, PM_TADDR, PM_ADDR} pm_kind_e;
    typedef enum logic [1:0] {SK_SHORT, SK_LONG, SK_TABLE_INDIRECT_INSTRUCTION} skipped_e;

    typedef struct packed {
        logic valid;
        dm_mode_e mode;
        byte_t offset;
        logic wide;
        bitpos_t bitpos;
    } dm_req_s;

    typedef struct packed {
        logic valid;
        bank_t accessed_bank;
        dm_addr_t address;
        bitpos_t bitpos;
        logic fault;
    } dm_ans_s;

    typedef struct packed {
        logic valid;
        pm_kind_e kind;
        pc_t pc;
        pc_t operand;
    } pm_req_s;

    typedef struct packed {
        logic valid;
        pc_t target;
        logic fault;
    } pm_ans_s;

    typedef struct packed {
        logic valid;
        logic taken;
        skipped_e kind;
    } sk_req_s;

endpackage

// ==== logic/bank_address_and_skip_timing.sv ====
// Operand bank resolution, program target checks and skip cycle timing
// Behaviour
// - DE/DL indirect always address bank zero
// - Flag clear: direct 00-7F bank 0, 80-FF bank 15
// - Flag set: direct uses selected bank 0/1/15
// - Fixed-bit operands: bank 15, FB0-FBF, FF0-FFF
// - Peripheral-bit operands: bank 15, FC0-FFF
// - Relative target: PC-15..PC-1 or PC+2..PC+16
// - 12-bit call address extended by PC bit 12
// - Short call address confined to 0000-07FF
// - Table entries 20-7F, even, locations 0020-007F
// - Absolute address limited to 1F7F
// - Skip not taken adds zero cycles
// - Skipping three-byte branch/call adds two cycles
// - Skipping table-indirect instruction takes one cycle
// - Machine cycle is one CPU clock; three lengths
// - Operand fields: 4, 8 and 2 bits
// - Reset: bank select zero, flag from boot bit
`timescale 1ns/100ps
`default_nettype none

module bank_address_and_skip_timing
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_bit7,
    input wire bank_timing_pkg::dm_req_s dm_req,
    output bank_timing_pkg::dm_ans_s dm_ans,
    input wire bank_timing_pkg::pm_req_s pm_req,
    output bank_timing_pkg::pm_ans_s pm_ans,
    input wire bank_timing_pkg::sk_req_s sk_req,
    output logic [1:0] skip_cycles,
    output logic skip_stall,
    output logic cpu_cycle_en
);

    typedef enum logic {SKIP_IDLE, SKIP_BUSY} skip_state_e;

    function automatic logic in_byte(input bank_timing_pkg::byte_t v,
                                     input bank_timing_pkg::byte_t lo,
                                     input bank_timing_pkg::byte_t hi);
        in_byte = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic in_pc(input bank_timing_pkg::pc_t v,
                                   input bank_timing_pkg::pc_t lo,
                                   input bank_timing_pkg::pc_t hi);
        in_pc = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic legal_bank(input bank_timing_pkg::bank_t b);
        legal_bank = (b == bank_timing_pkg::BANK_ZERO) || (b == bank_timing_pkg::BANK_ONE)
            || (b == bank_timing_pkg::BANK_TOP);
    endfunction

    logic bank_enable_flag_q;
    bank_timing_pkg::bank_t bank_select_register_q;
    logic [1:0] cpu_clock_control_register_q;
    logic boot_pending_q;
    logic [31:0] prdata_q;
    bank_timing_pkg::dm_ans_s dm_ans_q, dm_ans_d;
    bank_timing_pkg::pm_ans_s pm_ans_q, pm_ans_d;
    logic [5:0] mc_cnt_q;
    logic [1:0] skip_cycles_q, skip_left_q;
    skip_state_e skip_state_q;

    // APB decode; zero wait states, so pready only qualifies the access
    wire apb_access = psel && penable;
    wire apb_setup = psel && !penable;
    wire hit_ctrl = (paddr == bank_timing_pkg::CTRL_OFF);
    wire hit_stat = (paddr == bank_timing_pkg::STAT_OFF);
    wire unmapped = !(hit_ctrl || hit_stat);
    wire ctrl_wr = apb_access && pwrite && hit_ctrl;
    wire bank_enable_flag_d = pwdata[bank_timing_pkg::BE_POS];
    wire [3:0] bank_select_d = pwdata[bank_timing_pkg::BS_LSB +: 4];
    wire [1:0] pcc_d = pwdata[bank_timing_pkg::PCC_LSB +: 2];

    // Unlisted bank or clock settings leave the old value standing
    wire bs_ok = legal_bank(bank_select_d);
    wire pcc_ok = (pcc_d != 2'h3);

    assign pready = 1'b1;
    assign pslverr = apb_access && unmapped;
    assign prdata = prdata_q;

    logic [31:0] ctrl_word, stat_word;
    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[bank_timing_pkg::BE_POS] = bank_enable_flag_q;
        ctrl_word[bank_timing_pkg::BS_LSB +: 4] = bank_select_register_q;
        ctrl_word[bank_timing_pkg::PCC_LSB +: 2] = cpu_clock_control_register_q;
        stat_word = '0;
        stat_word[bank_timing_pkg::ST_BANK_LSB +: 4] = dm_ans_q.accessed_bank;
        stat_word[bank_timing_pkg::ST_SKIP_LSB +: 2] = skip_cycles_q;
        stat_word[bank_timing_pkg::ST_STALL_POS] = skip_stall;
        stat_word[bank_timing_pkg::ST_TARGET_LSB +: 13] = pm_ans_q.target;
    end

    wire [31:0] read_word = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0000_0000);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (apb_setup && !pwrite)
            prdata_q <= read_word;
    end

    // Boot bit is caught on the first edge after release, never by the reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            boot_pending_q <= 1'b1;
            bank_enable_flag_q <= 1'b0;
            bank_select_register_q <= bank_timing_pkg::BS_RST;
            cpu_clock_control_register_q <= bank_timing_pkg::PCC_RST;
        end
        else
        begin
            boot_pending_q <= 1'b0;
            if (boot_pending_q)
                bank_enable_flag_q <= boot_bit7;
            else if (ctrl_wr)
                bank_enable_flag_q <= bank_enable_flag_d;
            if (ctrl_wr && bs_ok)
                bank_select_register_q <= bank_select_d;
            if (ctrl_wr && pcc_ok)
                cpu_clock_control_register_q <= pcc_d;
        end
    end

    // Data memory bank resolution
    wire bank_zero_pair = (dm_req.mode == bank_timing_pkg::DM_DE)
        || (dm_req.mode == bank_timing_pkg::DM_DL);
    wire [3:0] sel_bank = bank_enable_flag_q ? bank_select_register_q
        : bank_timing_pkg::BANK_ZERO;
    wire [3:0] direct_bank = bank_enable_flag_q ? bank_select_register_q
        : ((dm_req.offset <= bank_timing_pkg::DIRECT_LOW_TOP) ? bank_timing_pkg::BANK_ZERO
        : bank_timing_pkg::BANK_TOP);
    wire fmem_ok = in_byte(dm_req.offset, bank_timing_pkg::FMEM_A_LO, bank_timing_pkg::FMEM_A_HI)
        || in_byte(dm_req.offset, bank_timing_pkg::FMEM_B_LO, bank_timing_pkg::FMEM_B_HI);
    wire pmem_ok = in_byte(dm_req.offset, bank_timing_pkg::PMEM_LO,
        bank_timing_pkg::PMEM_HI);
    // Odd byte-wide address is a coding fault upstream; flag, do not fix
    wire odd_wide = dm_req.wide && dm_req.offset[0];

    always_comb
    begin
        dm_ans_d = '0;
        dm_ans_d.valid = dm_req.valid;
        dm_ans_d.bitpos = dm_req.bitpos;
        case (dm_req.mode)
            bank_timing_pkg::DM_HL: dm_ans_d.accessed_bank = sel_bank;
            bank_timing_pkg::DM_DE, bank_timing_pkg::DM_DL:
                dm_ans_d.accessed_bank = bank_timing_pkg::BANK_ZERO;
            bank_timing_pkg::DM_MEM:
            begin
                dm_ans_d.accessed_bank = direct_bank;
                dm_ans_d.fault = odd_wide;
            end
            bank_timing_pkg::DM_FMEM:
            begin
                dm_ans_d.accessed_bank = bank_timing_pkg::BANK_TOP;
                dm_ans_d.fault = !fmem_ok;
            end
            bank_timing_pkg::DM_PMEM:
            begin
                dm_ans_d.accessed_bank = bank_timing_pkg::BANK_TOP;
                dm_ans_d.fault = !pmem_ok;
            end
            default: dm_ans_d.fault = 1'b1;
        endcase
        dm_ans_d.address = {dm_ans_d.accessed_bank, dm_req.offset};
    end

    // Program memory target checks
    wire [12:0] rel_back = pm_req.pc - pm_req.operand;
    wire [12:0] rel_fwd = pm_req.operand - pm_req.pc;
    wire rel_ok = in_pc(rel_back, bank_timing_pkg::REL_BACK_MIN, bank_timing_pkg::REL_BACK_MAX)
        || in_pc(rel_fwd, bank_timing_pkg::REL_FWD_MIN, bank_timing_pkg::REL_FWD_MAX);
    wire [12:0] caddr_target = {pm_req.pc[12], pm_req.operand[11:0]};
    wire [12:0] faddr_target = {2'b00, pm_req.operand[10:0]};
    wire taddr_ok = in_byte(pm_req.operand[7:0], bank_timing_pkg::TADDR_LO,
        bank_timing_pkg::TADDR_HI) && !pm_req.operand[0] && (pm_req.operand[12:8] == 5'h00);

    always_comb
    begin
        pm_ans_d = '0;
        pm_ans_d.valid = pm_req.valid;
        pm_ans_d.target = pm_req.operand;
        case (pm_req.kind)
            bank_timing_pkg::PM_REL: pm_ans_d.fault = !rel_ok;
            bank_timing_pkg::PM_CADDR:
            begin
                pm_ans_d.target = caddr_target;
                pm_ans_d.fault = caddr_target > bank_timing_pkg::ROM_TOP;
            end
            bank_timing_pkg::PM_FADDR: pm_ans_d.target = faddr_target;
            bank_timing_pkg::PM_TADDR: pm_ans_d.fault = !taddr_ok;
            bank_timing_pkg::PM_ADDR:
                pm_ans_d.fault = pm_req.operand > bank_timing_pkg::ROM_TOP;
            default: pm_ans_d.fault = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dm_ans_q <= '0;
            pm_ans_q <= '0;
        end
        else
        begin
            dm_ans_q <= dm_ans_d;
            pm_ans_q <= pm_ans_d;
        end
    end

    assign dm_ans = dm_ans_q;
    assign pm_ans = pm_ans_q;

    // CPU clock enable: one machine cycle per pulse
    wire [5:0] mc_len = (cpu_clock_control_register_q == 2'h0) ? bank_timing_pkg::MC_LEN_0
        : ((cpu_clock_control_register_q == 2'h1) ? bank_timing_pkg::MC_LEN_1
        : bank_timing_pkg::MC_LEN_2);
    wire mc_tick = (mc_cnt_q >= mc_len - 6'h01);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mc_cnt_q <= 6'h00;
        else
            mc_cnt_q <= mc_tick ? 6'h00 : mc_cnt_q + 6'h01;
    end

    assign cpu_cycle_en = mc_tick;

    // Skip cycle count and the stall it imposes on the core
    localparam bank_timing_pkg::skipped_e SK_LONG_K = bank_timing_pkg::SK_LONG;
    wire [1:0] skip_extra = !sk_req.taken ? bank_timing_pkg::SKIP_NONE
        : (sk_req.kind == SK_LONG_K) ? bank_timing_pkg::SKIP_LONG
        : bank_timing_pkg::SKIP_ONE;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            skip_state_q <= SKIP_IDLE;
            skip_cycles_q <= 2'h0;
            skip_left_q <= 2'h0;
        end
        else
        begin
            case (skip_state_q)
                SKIP_IDLE:
                    if (sk_req.valid)
                    begin
                        skip_cycles_q <= skip_extra;
                        skip_left_q <= skip_extra;
                        if (skip_extra != 2'h0)
                            skip_state_q <= SKIP_BUSY;
                    end
                SKIP_BUSY:
                    if (mc_tick)
                    begin
                        skip_left_q <= skip_left_q - 2'h1;
                        if (skip_left_q == 2'h1)
                            skip_state_q <= SKIP_IDLE;
                    end
                default: skip_state_q <= SKIP_IDLE;
            endcase
        end
    end

    assign skip_cycles = skip_cycles_q;
    assign skip_stall = (skip_state_q == SKIP_BUSY);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    hl_bank_a: assert property (dm_req.valid && dm_req.mode == bank_timing_pkg::DM_HL |=>
        dm_ans.accessed_bank == ($past(bank_enable_flag_q) ? $past(bank_select_register_q) : 4'h0))
        else $error("HL bank wrong");
    pair_zero_a: assert property (dm_req.valid && (dm_req.mode == bank_timing_pkg::DM_DE
        || dm_req.mode == bank_timing_pkg::DM_DL) |=> dm_ans.valid && dm_ans.accessed_bank == 4'h0)
        else $error("Pair bank not zero");
    direct_split_a: assert property (dm_req.valid && dm_req.mode == bank_timing_pkg::DM_MEM
        && !bank_enable_flag_q |=> dm_ans.accessed_bank == ($past(dm_req.offset[7]) ? 4'hF : 4'h0))
        else $error("Direct split wrong");
    direct_sel_a: assert property (dm_req.valid && dm_req.mode == bank_timing_pkg::DM_MEM
        && bank_enable_flag_q |=> dm_ans.accessed_bank == $past(bank_select_register_q))
        else $error("Direct bank not selected");
    fixed_bit_a: assert property (dm_req.valid && dm_req.mode == bank_timing_pkg::DM_FMEM |=>
        dm_ans.accessed_bank == 4'hF && dm_ans.fault == ($past(dm_req.offset[7:4]) != 4'hB
        && $past(dm_req.offset[7:4]) != 4'hF)) else $error("Fixed bit area wrong");
    periph_bit_a: assert property (dm_req.valid && dm_req.mode == bank_timing_pkg::DM_PMEM |=>
        dm_ans.accessed_bank == 4'hF && dm_ans.fault == ($past(dm_req.offset[7:6]) != 2'h3))
        else $error("Peripheral bit area wrong");
    rel_window_a: assert property (pm_req.valid && pm_req.kind == bank_timing_pkg::PM_REL
        && pm_req.operand == pm_req.pc + 13'h0011 |=> pm_ans.fault) else $error("Relative too far");
    table_entry_a: assert property (pm_req.valid && pm_req.kind == bank_timing_pkg::PM_TADDR
        && pm_req.operand[0] |=> pm_ans.fault) else $error("Odd table entry taken");
    skip_none_a: assert property (sk_req.valid && !sk_req.taken && !skip_stall |=>
        skip_cycles == 2'h0 && !skip_stall) else $error("Untaken skip stalls");
    skip_long_a: assert property (sk_req.valid && sk_req.taken && sk_req.kind == SK_LONG_K
        && !skip_stall |=> skip_cycles == 2'h2 && skip_stall) else $error("Long skip not two");
    // A clock control write on the next edge legally stretches this cycle
    cycle_len_a: assert property (mc_tick && cpu_clock_control_register_q == 2'h0
        && !ctrl_wr |=> !mc_tick ##1 (mc_tick || cpu_clock_control_register_q != 2'h0))
        else $error("Fast cycle length wrong");
    boot_flag_a: assert property (boot_pending_q |=> bank_enable_flag_q == $past(boot_bit7)
        && bank_select_register_q == 4'h0) else $error("Boot flag not loaded");

    hl_banked_c: cover property (dm_req.valid && dm_req.mode == bank_timing_pkg::DM_HL
        && bank_enable_flag_q && bank_select_register_q == 4'hF);
    long_skip_c: cover property (skip_stall [*3]);
    caddr_upper_c: cover property (pm_req.valid && pm_req.kind == bank_timing_pkg::PM_CADDR
        && pm_req.pc[12] ##1 !pm_ans.fault);

endmodule // bank_address_and_skip_timing

`default_nettype wire

// ==== verification/mem_partner.sv ====
// Model of the on-chip program and data memory beside the block
`timescale 1ns/100ps
`default_nettype none

module mem_partner
(
    input wire logic pclk,
    input wire logic [7:0] boot_word,
    input wire bank_timing_pkg::dm_ans_s dm_ans,
    output logic boot_bit7,
    output logic [15:0] hits
);
    // Word 0000H of the program image feeds the flag load
    assign boot_bit7 = boot_word[7];

    initial hits = 16'h0000;

    // Only clean accesses reach the array; faulted ones are dropped
    always @(posedge pclk)
    begin
        if (dm_ans.valid === 1'h1 && dm_ans.fault === 1'h0)
            hits <= hits + 16'h0001;
    end
endmodule // mem_partner

`default_nettype wire

// ==== verification/bank_address_and_skip_timing_bench.sv ====
// Self-checking bench for bank resolution, target checks and skip timing
`timescale 1ns/100ps
`default_nettype none

module bank_address_and_skip_timing_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic boot_bit7, skip_stall, cpu_cycle_en, err;
    logic [7:0] paddr, boot_word;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [1:0] skip_cycles;
    bank_timing_pkg::dm_req_s dm_req;
    bank_timing_pkg::dm_ans_s dm_ans;
    bank_timing_pkg::pm_req_s pm_req;
    bank_timing_pkg::pm_ans_s pm_ans;
    bank_timing_pkg::sk_req_s sk_req;
    int n_fail, cmp_count;

    bank_address_and_skip_timing DUT
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_bit7(boot_bit7), .dm_req(dm_req), .dm_ans(dm_ans), .pm_req(pm_req),
        .pm_ans(pm_ans), .sk_req(sk_req), .skip_cycles(skip_cycles),
        .skip_stall(skip_stall), .cpu_cycle_en(cpu_cycle_en)
    );

    mem_partner memory
    (
        .pclk(pclk), .boot_word(boot_word), .dm_ans(dm_ans), .boot_bit7(boot_bit7), .hits()
    );

    initial
    begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    function automatic logic [19:0] dm_exp(input bank_timing_pkg::dm_req_s r,
                                           input logic be, input logic [3:0] bs);
        logic [3:0] b;
        logic f;
        f = 1'h0;
        b = 4'h0;
        case (r.mode)
            bank_timing_pkg::DM_HL: b = be ? bs : 4'h0;
            bank_timing_pkg::DM_MEM:
            begin
                b = be ? bs : (r.offset[7] ? 4'hF : 4'h0);
                f = r.wide & r.offset[0];
            end
            bank_timing_pkg::DM_FMEM:
            begin
                b = 4'hF;
                f = !(r.offset inside {[8'hB0:8'hBF], [8'hF0:8'hFF]});
            end
            bank_timing_pkg::DM_PMEM:
            begin
                b = 4'hF;
                f = r.offset < 8'hC0;
            end
            default: ;
        endcase
        return {1'h1, b, b, r.offset, r.bitpos, f};
    endfunction

    function automatic logic [13:0] pm_exp(input bank_timing_pkg::pm_req_s q);
        logic [12:0] t, d1, d2;
        logic f;
        d1 = q.pc - q.operand;
        d2 = q.operand - q.pc;
        t = q.operand;
        f = q.operand > 13'h1F7F;
        case (q.kind)
            bank_timing_pkg::PM_REL:
                f = !((d1 >= 13'h0001 && d1 <= 13'h000F) || (d2 >= 13'h0002 && d2 <= 13'h0010));
            bank_timing_pkg::PM_CADDR:
            begin
                t = {q.pc[12], q.operand[11:0]};
                f = t > 13'h1F7F;
            end
            bank_timing_pkg::PM_FADDR:
            begin
                t = {2'h0, q.operand[10:0]};
                f = 1'h0;
            end
            bank_timing_pkg::PM_TADDR:
                f = !(q.operand inside {[13'h0020:13'h007F]}) || q.operand[0];
            default: ;
        endcase
        return {f, t};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic timeout;
        n_fail++;
        $display("[ERR] wait expected answer seen none");
        print_verdict();
    endtask

    task automatic do_reset(input logic [7:0] w);
        presetn <= 1'h0;
        boot_word <= w;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
    endtask

    // Entered just after an edge; leaves one idle edge so psel is never set twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 16);
        if (n >= 16)
            timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic wait_en(output int n);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (cpu_cycle_en !== 1'h1 && n < 100);
        if (n >= 100)
            timeout();
    endtask

    initial
    begin
        int i, n, cnt;
        logic be;
        logic [13:0] e;
        logic [19:0] x;
        bank_timing_pkg::dm_req_s r;
        bank_timing_pkg::pm_req_s q;
        static logic [3:0] cfg_bs [4] = '{4'h0, 4'h0, 4'h1, 4'hF};
        static logic [12:0] rel_d [8] = '{13'h1FF0, 13'h1FF1, 13'h1FFF, 13'h0000,
                                          13'h0001, 13'h0002, 13'h0010, 13'h0011};
        static logic [5:0] mc [3] = '{bank_timing_pkg::MC_LEN_0, bank_timing_pkg::MC_LEN_1,
                                      bank_timing_pkg::MC_LEN_2};
        static bank_timing_pkg::skipped_e sk_kind [4] = '{bank_timing_pkg::SK_LONG,
            bank_timing_pkg::SK_LONG, bank_timing_pkg::SK_TABLE_INDIRECT_INSTRUCTION, bank_timing_pkg::SK_SHORT};
        static logic [1:0] sk_exp [4] = '{2'h0, 2'h2, 2'h1, 2'h1};
        n_fail = 0;
        cmp_count = 0;
        seed = 32'hE4D2D12F;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        dm_req = '0;
        pm_req = '0;
        sk_req = '0;
        do_reset(8'h80);
        apb(1'h0, bank_timing_pkg::CTRL_OFF, 32'h00000000);
        check("ctrl after reset", rd, 32'h00000001);
        check("mapped error", {31'h0, err}, 32'h00000000);
        apb(1'h0, 8'h08, 32'h00000000);
        check("unmapped error", {31'h0, err}, 32'h00000001);
        check("unmapped data", rd, 32'h00000000);
        $display("test reset done");

        for (int c = 0; c < 4; c++)
        begin
            be = (c != 0);
            apb(1'h1, bank_timing_pkg::CTRL_OFF, {24'h0, cfg_bs[c], 3'h0, be});
            for (i = 0; i < 24; i++)
            begin
                seed = lfsr(seed);
                r.valid = 1'h1;
                r.mode = bank_timing_pkg::dm_mode_e'(seed[2:0] % 3'h6);
                r.offset = seed[15:8];
                r.wide = seed[4];
                r.bitpos = seed[6:5];
                if (r.wide)
                    r.offset[0] = 1'h0;
                // Bank boundary, then one odd byte-wide operand on purpose
                if (i < 3)
                begin
                    r.mode = bank_timing_pkg::DM_MEM;
                    r.offset = 8'h7F + i[7:0];
                    r.wide = (i == 2);
                end
                dm_req <= r;
                @(posedge pclk);
                dm_req.valid <= 1'h0;
                @(posedge pclk);
                check("dm answer", dm_ans, dm_exp(r, be, cfg_bs[c]));
            end
        end
        apb(1'h1, bank_timing_pkg::CTRL_OFF, 32'h00000350);
        apb(1'h0, bank_timing_pkg::CTRL_OFF, 32'h00000000);
        check("ctrl illegal write", rd, 32'h000000F0);
        $display("test data banks done");

        for (i = 0; i < 60; i++)
        begin
            seed = lfsr(seed);
            q.valid = 1'h1;
            q.kind = bank_timing_pkg::pm_kind_e'(seed[2:0] % 3'h5);
            q.pc = seed[15:3];
            q.operand = seed[28:16];
            if (q.kind == bank_timing_pkg::PM_TADDR && seed[31])
                q.operand[12:8] = 5'h00;
            if (q.kind == bank_timing_pkg::PM_REL)
                q.operand = q.pc + {{7{seed[21]}}, seed[21:16]};
            if (i < 8)
            begin
                q.kind = bank_timing_pkg::PM_REL;
                q.operand = q.pc + rel_d[i];
            end
            pm_req <= q;
            @(posedge pclk);
            pm_req.valid <= 1'h0;
            @(posedge pclk);
            e = pm_exp(q);
            check("pm fault", {pm_ans.valid, pm_ans.fault}, {1'h1, e[13]});
            if (q.kind != bank_timing_pkg::PM_REL)
                check("pm target", pm_ans.target, e[12:0]);
        end
        $display("test program targets done");

        for (i = 0; i < 3; i++)
        begin
            apb(1'h1, bank_timing_pkg::CTRL_OFF, {22'h0, i[1:0], 8'h00});
            repeat (3) wait_en(n);
            check("cycle length", n, mc[i]);
            for (int k = 0; k < 4; k++)
            begin
                sk_req <= '{1'h1, k != 0, sk_kind[k]};
                @(posedge pclk);
                sk_req.valid <= 1'h0;
                @(posedge pclk);
                check("skip cycles", skip_cycles, sk_exp[k]);
                cnt = 0;
                n = 0;
                while (skip_stall === 1'h1 && n < 200)
                begin
                    if (cpu_cycle_en === 1'h1)
                        cnt++;
                    n++;
                    @(posedge pclk);
                end
                if (n >= 200)
                    timeout();
                check("stall pulses", cnt, sk_exp[k]);
            end
        end
        // Status mirrors the last skip and the still-held data and program requests
        e = pm_exp(q);
        x = dm_exp(r, 1'h0, 4'h0);
        apb(1'h0, bank_timing_pkg::STAT_OFF, 32'h00000000);
        check("status word", rd, {3'h0, e[12:0], 7'h00, 1'h0, 2'h0, 2'h1, x[18:15]});
        $display("test skip timing done");

        do_reset(8'h00);
        check("skip after reset", skip_cycles, 2'h0);
        apb(1'h0, bank_timing_pkg::CTRL_OFF, 32'h00000000);
        check("ctrl second reset", rd, 32'h00000000);
        $display("test second reset done");
        print_verdict();
    end
endmodule // bank_address_and_skip_timing_bench

`default_nettype wire
